// [pkg/lcd_pkg.sv]
// Shared constants and types for the serial character display interpreter.
package lcd_pkg;
  localparam int CLK_HZ    = 125_000_000;
  localparam int CLK_NS    = 8;
  localparam int BAUD      = 9600;
  localparam int BIT_CYC   = CLK_HZ / BAUD;
  localparam int EN_NS     = 500;
  localparam int EN_CYC    = (EN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SHORT_US  = 50;
  localparam int SHORT_CYC = (SHORT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int LONG_US   = 2000;
  localparam int LONG_CYC  = (LONG_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PWR_MS    = 40;
  localparam int PWR_CYC   = PWR_MS * (CLK_HZ / 1000);
  localparam int HOLD_MS   = 1000;
  localparam int HOLD_CYC  = HOLD_MS * (CLK_HZ / 1000);
  localparam int BEEP_HZ   = 500;
  localparam int BEEP_MS   = 50;
  localparam int BEEP_CYC  = BEEP_MS * (CLK_HZ / 1000);
  localparam int HALF_CYC  = CLK_HZ / (2 * BEEP_HZ);
  localparam int RX_DEPTH  = 64;

  localparam logic [2:0] ROWS_DEF  = 3'h4;
  localparam logic [5:0] COLS_DEF  = 6'h14;
  localparam logic [3:0] TAB_DEF   = 4'h4;
  localparam logic [1:0] STYLE_DEF = 2'h3;

  localparam logic [7:0] CH_PREFIX = 8'h3f;
  localparam logic [7:0] CH_SPACE  = 8'h20;
  localparam logic [7:0] CH_ZERO   = 8'h30;
  localparam logic [7:0] CH_SEVEN  = 8'h37;
  localparam logic [7:0] CH_NINE   = 8'h39;
  localparam logic [7:0] CH_X      = 8'h78;
  localparam logic [7:0] CH_C      = 8'h63;
  localparam logic [7:0] KEY_HOME  = 8'h61;
  localparam logic [7:0] KEY_BS    = 8'h62;
  localparam logic [7:0] KEY_CLS   = 8'h66;
  localparam logic [7:0] KEY_BEEP  = 8'h67;
  localparam logic [7:0] KEY_BACK  = 8'h68;
  localparam logic [7:0] KEY_FWD   = 8'h69;
  localparam logic [7:0] KEY_DOWN  = 8'h6a;
  localparam logic [7:0] KEY_UP    = 8'h6b;
  localparam logic [7:0] KEY_LINE  = 8'h6c;
  localparam logic [7:0] KEY_CR    = 8'h6d;
  localparam logic [7:0] KEY_NL    = 8'h6e;
  localparam logic [7:0] KEY_TAB   = 8'h74;
  localparam logic [7:0] KEY_COL   = 8'h78;
  localparam logic [7:0] KEY_ROW   = 8'h79;
  localparam logic [7:0] KEY_GEOM  = 8'h47;

  localparam logic [7:0] CMD_WAKE1 = 8'h33;
  localparam logic [7:0] CMD_WAKE2 = 8'h32;
  localparam logic [7:0] CMD_FUNC  = 8'h28;
  localparam logic [7:0] CMD_DISP  = 8'h0c;
  localparam logic [7:0] CMD_ENTRY = 8'h06;
  localparam logic [7:0] CMD_CLEAR = 8'h01;
  localparam logic [7:0] CMD_CGRAM = 8'h40;
  localparam logic [7:0] CMD_DDRAM = 8'h80;
  localparam logic [6:0] ROW_ODD   = 7'h40;
  localparam logic [6:0] GLYPH0    = 7'h07;
  localparam logic [6:0] INIT_LAST = 7'h47;
  localparam logic [2:0] SHOW_LAST = 3'h6;
  localparam logic [7:0] TEST_LO   = 8'h20;
  localparam logic [7:0] TEST_HI   = 8'h7e;
  localparam logic [3:0] NV_GEOM   = 4'h0;

  typedef struct packed {
    logic       rs;
    logic       en;
    logic [3:0] data;
  } lcd_bus_type;

  typedef struct packed {
    logic       we;
    logic [3:0] addr;
    logic [7:0] data;
  } nv_write_type;

  typedef enum logic [3:0] {
    S_PWR = 4'h0, S_INIT = 4'h1, S_SHOW = 4'h3, S_HOLD = 4'h2,
    S_IDLE = 4'h6, S_CMD = 4'h7, S_POS = 4'h5, S_BLANK = 4'h4,
    S_ARGY = 4'hc, S_ARGX1 = 4'hd, S_ARGX2 = 4'hf, S_G1 = 4'he,
    S_G2 = 4'ha, S_G3 = 4'hb, S_TEST = 4'h9
  } state_type;
endpackage

// [rtl/rx_buffer.sv]
// Serial frame receiver with a byte buffer in front of the interpreter.
`timescale 1ns/1ps
module rx_buffer #(
  parameter int BIT_CYC = lcd_pkg::BIT_CYC,
  parameter int DEPTH   = lcd_pkg::RX_DEPTH
) (
  input  wire logic       clk_sys,   // System clock
  input  wire logic       rst_b,     // Asynchronous reset, active low
  input  wire logic       serial_in, // Serial line, idle high
  input  wire logic       rd_ready,  // Consumer takes the head byte
  output logic            rd_valid,  // Head byte present
  output logic [7:0]      rd_data,   // Head byte
  output logic            overrun    // Byte lost to a full buffer
);
  import lcd_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam logic [13:0] BIT_END  = 14'(BIT_CYC - 1);
  localparam logic [13:0] HALF_END = 14'(BIT_CYC / 2 - 1);
  if (BIT_CYC < 4 || BIT_CYC > 16384 || DEPTH != (1 << AW))
    $error("rx_buffer: bad bit time or depth");

  typedef struct packed {
    logic          s1, s2, busy, ovr;
    logic [3:0]    bitn;
    logic [13:0]   cnt;
    logic [7:0]    sh;
    logic [AW-1:0] wp, rp;
    logic [AW:0]   fill;
  } rx_type;

  rx_type r, n;
  logic   push;
  logic [7:0] mem [DEPTH];

  always_comb begin
    n = r;
    push = 1'b0;
    n.s1 = serial_in;
    n.s2 = r.s1;
    n.ovr = 1'b0;
    if (!r.busy) begin
      n.cnt = '0;
      n.bitn = '0;
      n.busy = !r.s2;
    end else if (r.bitn == 4'h0) begin
      if (r.cnt == HALF_END) begin
        n.cnt = '0;
        n.bitn = 4'h1;
        n.busy = !r.s2;
      end else n.cnt = r.cnt + 14'h1;
    end else if (r.cnt == BIT_END) begin
      n.cnt = '0;
      n.bitn = r.bitn + 4'h1;
      if (r.bitn == 4'h9) begin
        n.busy = 1'b0;
        push = r.s2 && (r.fill != (AW+1)'(DEPTH));
        n.ovr = r.s2 && !push;
      end else n.sh = {r.s2, r.sh[7:1]};
    end else n.cnt = r.cnt + 14'h1;
    if (push) n.wp = r.wp + 1'b1;
    if (rd_ready && rd_valid) n.rp = r.rp + 1'b1;
    n.fill = r.fill + (AW+1)'(push) - (AW+1)'(rd_ready && rd_valid);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) r <= '{s1: 1'b1, s2: 1'b1, default: '0};
    else r <= n;
  end

  always_ff @(posedge clk_sys) begin
    if (push) mem[r.wp] <= r.sh;
  end

  assign rd_valid = (r.fill != '0);
  assign rd_data  = mem[r.rp];
  assign overrun  = r.ovr;

  fill_bound_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    r.fill == (AW+1)'(DEPTH) && !(rd_ready && rd_valid) |=> r.fill == (AW+1)'(DEPTH))
    else $error("Full buffer changed fill without a read.");
  stop_check_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    push |-> r.bitn == 4'h9 && r.s2 && r.cnt == BIT_END)
    else $error("Byte stored outside a valid stop bit.");
endmodule

// [rtl/serial_lcd.sv]
// Serial text and command interpreter driving a character display in nibble mode.
`timescale 1ns/1ps
// How it works
// - Commands start with a question mark; the following letter is case sensitive.
// - Command a homes the cursor and leaves the screen text alone.
// - Backspaces, forward, down and up move the cursor within the set geometry.
// - Command f clears the whole screen and homes the cursor.
// - Command g sounds the piezo at 500 Hz for 50 ms, then idles it.
// - Clear-line blanks the current row and leaves the cursor at column zero.
// - Command m returns the cursor to column zero of the same row.
// - Command n moves to the next row start and blanks that row.
// - Command t blanks forward to the next stop of the stored tab size.
// - Command y takes one row digit; command x takes two column digits.
// - Rows and columns count from zero; 4x20 gives rows 0-3, columns 00-19.
// - A question mark then digit 0-7 writes that user glyph at the cursor.
// - Each printed character advances the cursor by the geometry.
// - Geometry changes go to nonvolatile storage; style, tab and glyphs stay at their defaults.
// - At boot outside test mode the default geometry and cursor style are shown briefly.
// - Defaults: four rows, twenty columns, tab four, style three, line glyphs.
// - Geometry takes one row and two column digits; only six sizes are accepted.
// - Up to 64 received bytes are buffered; the host paces its output.
// - The display is driven four bits at a time on its upper data lines.
// - A grounded test input at power-up selects test mode over serial commands.
// - Test mode scrolls an endless repeating character stream after a pause.
module serial_lcd #(
  parameter int BIT_CYC   = lcd_pkg::BIT_CYC,
  parameter int SHORT_CYC = lcd_pkg::SHORT_CYC,
  parameter int LONG_CYC  = lcd_pkg::LONG_CYC,
  parameter int PWR_CYC   = lcd_pkg::PWR_CYC,
  parameter int HOLD_CYC  = lcd_pkg::HOLD_CYC,
  parameter int BEEP_CYC  = lcd_pkg::BEEP_CYC,
  parameter int HALF_CYC  = lcd_pkg::HALF_CYC
) (
  input  wire logic           clk_sys,           // 125 MHz system clock
  input  wire logic           rst_b,             // Asynchronous reset, active low
  input  wire logic           serial_data,       // Serial input, idle high
  input  wire logic           test_mode_header_b, // Low selects test mode
  output lcd_pkg::lcd_bus_type lcd,              // Display select, enable, nibble
  output logic                piezo,             // Beeper square wave
  output lcd_pkg::nv_write_type nv,              // Storage write strobe
  output logic                rx_overrun         // Received byte dropped
);
  import lcd_pkg::*;
  localparam logic [17:0] EN_END    = 18'(EN_CYC - 1);
  localparam logic [17:0] SHORT_END = 18'(SHORT_CYC - 1);
  localparam logic [17:0] LONG_END  = 18'(LONG_CYC - 1);
  localparam logic [26:0] PWR_END   = 27'(PWR_CYC - 1);
  localparam logic [26:0] HOLD_END  = 27'(HOLD_CYC - 1);
  localparam logic [22:0] BEEP_END  = 23'(BEEP_CYC);
  localparam logic [16:0] HALF_END  = 17'(HALF_CYC - 1);
  if (LONG_CYC > 262144 || SHORT_CYC < 1 || HOLD_CYC > 134217728 ||
      PWR_CYC > 134217728 || BEEP_CYC > 8388607 || HALF_CYC > 131072)
    $error("serial_lcd: count does not fit its counter");

  typedef struct packed {
    state_type    st;
    logic         ts1, ts2, test;
    logic [26:0]  tmr;
    logic [6:0]   idx;
    logic [2:0]   rows, arow;
    logic [5:0]   cols, col, tcol, blank;
    logic [1:0]   row, style;
    logic [3:0]   tab, atens;
    logic [7:0]   tch;
    logic         wbusy, wlong, wrs;
    logic [7:0]   wbyte;
    logic [2:0]   wph;
    logic [17:0]  wcnt;
    logic [22:0]  beep_left;
    logic [16:0]  beep_ph;
    logic         piezo;
    lcd_bus_type  lcd;
    nv_write_type nv;
  } ctl_type;

  localparam ctl_type CTL_RST = '{st: S_PWR, ts1: 1'b1, ts2: 1'b1, rows: ROWS_DEF,
    cols: COLS_DEF, tab: TAB_DEF, style: STYLE_DEF, tch: TEST_LO, default: '0};

  ctl_type    r, n;
  logic       pop, rx_valid, take;
  logic [7:0] rx_data;

  rx_buffer #(.BIT_CYC(BIT_CYC), .DEPTH(RX_DEPTH)) u_rx (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .serial_in(serial_data),
    .rd_ready (pop),
    .rd_valid (rx_valid),
    .rd_data  (rx_data),
    .overrun  (rx_overrun)
  );

  function automatic logic geom_ok(input logic [2:0] gr, input logic [6:0] gc);
    return (gr == 3'h2 && (gc == 7'h10 || gc == 7'h14 || gc == 7'h18 || gc == 7'h28)) ||
           (gr == 3'h4 && (gc == 7'h10 || gc == 7'h14));
  endfunction

  // Rows 2 and 3 continue after rows 0 and 1 in display memory.
  function automatic logic [7:0] ddram(input logic [1:0] rw, input logic [5:0] c,
                                       input logic [5:0] w);
    logic [6:0] a;
    a = (rw[0] ? ROW_ODD : 7'h00) + (rw[1] ? {1'b0, w} : 7'h00) + {1'b0, c};
    return CMD_DDRAM | {1'b0, a};
  endfunction

  function automatic logic [1:0] next_row(input logic [1:0] rw, input logic [2:0] nr);
    return ({1'b0, rw} == nr - 3'h1) ? 2'h0 : rw + 2'h1;
  endfunction

  function automatic logic [1:0] prev_row(input logic [1:0] rw, input logic [2:0] nr);
    return (rw == 2'h0) ? 2'(nr - 3'h1) : rw - 2'h1;
  endfunction

  // Returns {row, col} one place forward or back, wrapping rows.
  function automatic logic [7:0] step(input ctl_type s, input logic fwd);
    if (fwd)
      return (s.col == s.cols - 6'h1) ? {next_row(s.row, s.rows), 6'h0}
                                      : {s.row, s.col + 6'h1};
    return (s.col == 6'h0) ? {prev_row(s.row, s.rows), s.cols - 6'h1}
                           : {s.row, s.col - 6'h1};
  endfunction

  function automatic ctl_type send(input ctl_type s, input logic [7:0] b, input logic rs);
    s.wbusy = 1'b1;
    s.wbyte = b;
    s.wrs   = rs;
    s.wph   = 3'h0;
    s.wcnt  = '0;
    s.wlong = !rs && (b < 8'h04 || b[7:4] == 4'h3);
    return s;
  endfunction

  // Prints a byte and moves on; the address is rewritten since rows are not contiguous.
  function automatic ctl_type put(input ctl_type s, input logic [7:0] b);
    s = send(s, b, 1'b1);
    {s.row, s.col} = step(s, 1'b1);
    s.st = S_POS;
    return s;
  endfunction

  function automatic logic [7:0] init_byte(input logic [6:0] i, input logic [1:0] sty);
    logic [5:0] k;
    k = 6'(i - GLYPH0);
    case (i)
      7'h00:     return CMD_WAKE1;
      7'h01:     return CMD_WAKE2;
      7'h02:     return CMD_FUNC;
      7'h03:     return CMD_DISP | {6'h0, sty};
      7'h04:     return CMD_ENTRY;
      7'h05:     return CMD_CLEAR;
      7'h06:     return CMD_CGRAM;
      INIT_LAST: return CMD_DDRAM;
      default:   return (k[2:0] >= 3'h7 - k[5:3]) ? 8'h1f : 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] show_char(input logic [2:0] i, input ctl_type s);
    case (i)
      3'h0:    return CH_ZERO + {5'h0, s.rows};
      3'h1:    return CH_X;
      3'h2:    return CH_ZERO + 8'(s.cols / 6'h0a);
      3'h3:    return CH_ZERO + 8'(s.cols % 6'h0a);
      3'h4:    return CH_SPACE;
      3'h5:    return CH_C;
      default: return CH_ZERO + {6'h0, s.style};
    endcase
  endfunction

  assign take = !r.wbusy && rx_valid && r.st == S_CMD;

  always_comb begin
    logic       dig_ok;
    logic [7:0] dig;
    logic [6:0] val;
    logic [5:0] run;
    n = r;
    pop = 1'b0;
    dig = rx_data - CH_ZERO;
    dig_ok = rx_data >= CH_ZERO && rx_data <= CH_NINE;
    val = 7'(r.atens) * 7'h0a + 7'(dig[3:0]);
    run = 6'(r.tab) - (r.col % 6'(r.tab));
    n.ts1 = test_mode_header_b;
    n.ts2 = r.ts1;
    n.nv.we = 1'b0;
    if (r.beep_left != '0) begin
      n.beep_left = r.beep_left - 23'h1;
      n.beep_ph = (r.beep_ph == HALF_END) ? 17'h0 : r.beep_ph + 17'h1;
      if (r.beep_ph == HALF_END) n.piezo = !r.piezo;
    end else begin
      n.beep_ph = '0;
      n.piezo = 1'b0;
    end
    if (r.wbusy) begin
      // Phases: upper setup, upper enable, lower setup, lower enable, settle.
      if (r.wcnt == ((r.wph == 3'h4) ? (r.wlong ? LONG_END : SHORT_END) : EN_END)) begin
        n.wcnt = '0;
        if (r.wph == 3'h4) n.wbusy = 1'b0;
        else n.wph = r.wph + 3'h1;
      end else n.wcnt = r.wcnt + 18'h1;
    end else begin
      unique case (r.st)
        S_PWR: begin
          n.tmr = r.tmr + 27'h1;
          if (r.tmr == PWR_END) begin
            n.tmr = '0;
            n.test = !r.ts2;
            n.st = S_INIT;
          end
        end
        S_INIT: begin
          n = send(n, init_byte(r.idx, r.style), r.idx >= GLYPH0 && r.idx < INIT_LAST);
          n.idx = (r.idx == INIT_LAST) ? 7'h0 : r.idx + 7'h1;
          if (r.idx == INIT_LAST) n.st = S_SHOW;
        end
        S_SHOW: begin
          if (r.test) n.st = S_HOLD;
          else begin
            n = send(n, show_char(r.idx[2:0], r), 1'b1);
            n.idx = r.idx + 7'h1;
            if (r.idx[2:0] == SHOW_LAST) n.st = S_HOLD;
          end
        end
        S_HOLD: begin
          n.tmr = r.tmr + 27'h1;
          if (r.tmr == HOLD_END) begin
            n = send(n, CMD_CLEAR, 1'b0);
            n.tmr = '0;
            n.row = '0;
            n.col = '0;
            n.st = r.test ? S_TEST : S_IDLE;
          end
        end
        S_IDLE: if (rx_valid) begin
          pop = 1'b1;
          if (rx_data == CH_PREFIX) n.st = S_CMD;
          else n = put(n, rx_data);
        end
        S_CMD: if (rx_valid) begin
          pop = 1'b1;
          n.st = S_POS;
          case (rx_data)
            CH_PREFIX: n = put(n, CH_PREFIX);
            KEY_HOME:  {n.row, n.col} = 8'h00;
            KEY_BS: begin
              {n.row, n.col} = step(r, 1'b0);
              n.tcol = n.col;
              n.blank = 6'h1;
            end
            KEY_CLS: begin
              n = send(n, CMD_CLEAR, 1'b0);
              {n.row, n.col} = 8'h00;
              n.st = S_IDLE;
            end
            KEY_BEEP: begin
              n.beep_left = BEEP_END;
              n.st = S_IDLE;
            end
            KEY_BACK:  {n.row, n.col} = step(r, 1'b0);
            KEY_FWD:   {n.row, n.col} = step(r, 1'b1);
            KEY_DOWN:  n.row = next_row(r.row, r.rows);
            KEY_UP:    n.row = prev_row(r.row, r.rows);
            KEY_LINE, KEY_NL: begin
              if (rx_data == KEY_NL) n.row = next_row(r.row, r.rows);
              n.col = '0;
              n.tcol = '0;
              n.blank = r.cols;
            end
            KEY_CR:    n.col = '0;
            KEY_TAB: begin
              // A stop past the line end stops at the last column.
              n.blank = (run >= r.cols - r.col) ? r.cols - r.col : run;
              n.tcol = (run >= r.cols - r.col) ? r.cols - 6'h1 : r.col + run;
            end
            KEY_ROW:   n.st = S_ARGY;
            KEY_COL:   n.st = S_ARGX1;
            KEY_GEOM:  n.st = S_G1;
            default: begin
              if (rx_data >= CH_ZERO && rx_data <= CH_SEVEN) n = put(n, dig);
              else n.st = S_IDLE;
            end
          endcase
        end
        S_POS: begin
          n = send(n, ddram(r.row, r.col, r.cols), 1'b0);
          n.st = (r.blank != '0) ? S_BLANK : (r.test ? S_TEST : S_IDLE);
        end
        S_BLANK: begin
          n = send(n, CH_SPACE, 1'b1);
          n.blank = r.blank - 6'h1;
          if (r.blank == 6'h1) begin
            n.col = r.tcol;
            n.st = S_POS;
          end
        end
        S_ARGY: if (rx_valid) begin
          pop = 1'b1;
          n.st = S_IDLE;
          if (dig_ok && dig < {5'h0, r.rows}) begin
            n.row = dig[1:0];
            n.st = S_POS;
          end
        end
        S_ARGX1, S_G2: if (rx_valid) begin
          pop = 1'b1;
          n.atens = dig[3:0];
          n.st = !dig_ok ? S_IDLE : (r.st == S_G2 ? S_G3 : S_ARGX2);
        end
        S_ARGX2: if (rx_valid) begin
          pop = 1'b1;
          n.st = S_IDLE;
          if (dig_ok && val < {1'b0, r.cols}) begin
            n.col = val[5:0];
            n.st = S_POS;
          end
        end
        S_G1: if (rx_valid) begin
          pop = 1'b1;
          n.arow = dig[2:0];
          n.st = dig_ok ? S_G2 : S_IDLE;
        end
        S_G3: if (rx_valid) begin
          pop = 1'b1;
          n.st = S_IDLE;
          if (dig_ok && geom_ok(r.arow, val)) begin
            n.rows = r.arow;
            n.cols = val[5:0];
            {n.row, n.col} = 8'h00;
            n.nv = '{we: 1'b1, addr: NV_GEOM, data: {r.arow[2], 1'b0, val[5:0]}};
            n = send(n, CMD_CLEAR, 1'b0);
          end
        end
        S_TEST: begin
          n = put(n, r.tch);
          n.tch = (r.tch == TEST_HI) ? TEST_LO : r.tch + 8'h1;
        end
      endcase
    end
    n.lcd.rs = n.wrs;
    n.lcd.data = (n.wph < 3'h2) ? n.wbyte[7:4] : n.wbyte[3:0];
    n.lcd.en = n.wbusy && n.wph[0];
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) r <= CTL_RST;
    else r <= n;
  end

  assign lcd   = r.lcd;
  assign piezo = r.piezo;
  assign nv    = r.nv;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  en_stable_a: assert property (
    r.lcd.en && $past(r.lcd.en) |-> $stable(r.lcd.data) && $stable(r.lcd.rs))
    else $error("Display bus moved while enable high.");
  upper_first_a: assert property (
    $rose(r.lcd.en) |-> (r.wph == 3'h1 && r.lcd.data == r.wbyte[7:4]) ||
                        (r.wph == 3'h3 && r.lcd.data == r.wbyte[3:0]))
    else $error("Nibble order wrong at enable.");
  beep_start_a: assert property (
    take && rx_data == KEY_BEEP |=> r.beep_left == BEEP_END)
    else $error("Beep not started with full length.");
  piezo_idle_a: assert property (
    r.beep_left == '0 |=> !r.piezo)
    else $error("Piezo active after beep end.");
  home_a: assert property (
    take && rx_data == KEY_HOME |=> r.row == 2'h0 && r.col == 6'h0 && r.st == S_POS)
    else $error("Home did not reach row 0 column 0.");
  cr_a: assert property (
    take && rx_data == KEY_CR |=> r.col == 6'h0 && r.row == $past(r.row))
    else $error("Return changed row or missed column 0.");
  line_clear_a: assert property (
    take && rx_data == KEY_LINE |=> r.blank == r.cols && r.col == 6'h0 && r.st == S_POS ##1 r.st == S_BLANK)
    else $error("Line clear not set up.");
  bounds_a: assert property (
    {1'b0, r.row} < r.rows && r.col < r.cols)
    else $error("Cursor outside geometry.");
  geom_a: assert property (
    geom_ok(r.rows, {1'b0, r.cols}))
    else $error("Unsupported geometry held.");
  test_quiet_a: assert property (
    r.test |-> !pop)
    else $error("Serial byte consumed in test mode.");

  beep_c: cover property (take && rx_data == KEY_BEEP ##1 r.beep_left != '0);
  geom_c: cover property (r.nv.we);
  glyph_c: cover property (take && rx_data == CH_SEVEN);
  test_c: cover property (r.st == S_TEST);
endmodule

// [test/host_model.sv]
// Host side model that sends text and commands as serial frames.
`timescale 1ns/1ps
module host_model #(
  parameter int BIT_CYC = 16
) (
  input  wire logic clk_sys,    // System clock
  output logic      serial_data // Serial line to the device, idle high
);
  initial serial_data = 1'b1;

  // One start bit, eight data bits least significant first, one stop bit.
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      #1 serial_data = f[i];
      repeat (BIT_CYC - 1) @(posedge clk_sys);
    end
  endtask

  // Commands are a prefix, a letter and the digits that letter takes.
  task automatic cmd(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send(s[i]);
    end
  endtask
endmodule

// [test/serial_lcd_command_interpreter_tb.sv]
// Self-checking bench for the serial display interpreter.
`timescale 1ns/1ps
module serial_lcd_command_interpreter_tb;
  import lcd_pkg::*;
  logic         clk_sys = 1'b0;
  logic         rst_b = 1'b0;
  logic         serial_data;
  lcd_bus_type  lcd;
  nv_write_type nv;
  nv_write_type nv_seen = '0;
  logic         piezo, rx_overrun, piezo_prev = 1'b0, en_prev = 1'b0, hi = 1'b1, tm_b = 1'b1;
  logic [3:0]   up;
  logic [8:0]   q[$];
  logic [7:0]   c;
  int           errors = 0, comparisons = 0, toggles = 0, t0, ovr_n = 0;
  string        s = "x20 c3";
  // Shortened timing so that boot, beep and bytes fit a short run.
  localparam int BIT_T = 16, SHORT_T = 4, LONG_T = 8, PWR_T = 10, HOLD_T = 20, BEEP_T = 100, HALF_T = 10;

  always #4 clk_sys = ~clk_sys;

  host_model #(.BIT_CYC(BIT_T)) host (.clk_sys(clk_sys), .serial_data(serial_data));

  serial_lcd #(.BIT_CYC(BIT_T), .SHORT_CYC(SHORT_T), .LONG_CYC(LONG_T), .PWR_CYC(PWR_T), .HOLD_CYC(HOLD_T),
    .BEEP_CYC(BEEP_T), .HALF_CYC(HALF_T)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .serial_data(serial_data), .test_mode_header_b(tm_b), .lcd(lcd), .piezo(piezo),
    .nv(nv), .rx_overrun(rx_overrun));

  // Bytes are rebuilt from the two nibbles latched at each rising enable.
  always @(posedge clk_sys) begin
    en_prev <= lcd.en;
    piezo_prev <= piezo;
    if (piezo !== piezo_prev) toggles <= toggles + 1;
    if (rx_overrun === 1'b1) ovr_n <= ovr_n + 1;
    if (nv.we === 1'b1) nv_seen <= nv;
    if (!rst_b) hi <= 1'b1;
    else if (lcd.en === 1'b1 && en_prev === 1'b0) begin
      if (hi) up <= lcd.data;
      else q.push_back({lcd.rs, up, lcd.data});
      hi <= !hi;
    end
  end

  task automatic end_sim;
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic pop(output logic [8:0] v);
    int n = 0;
    while (q.size() == 0 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    if (q.size() == 0) begin
      check(1'b0, "display wait timed out");
      end_sim();
    end else v = q.pop_front();
  endtask

  task automatic expect_b(input logic [8:0] e);
    logic [8:0] v;
    pop(v);
    check(v === e, "display byte mismatch");
  endtask

  // Skips display traffic whose exact length this bench does not model.
  task automatic find(input logic [8:0] e);
    logic [8:0] v = '1;
    for (int i = 0; i < 200 && v !== e; i++) pop(v);
    check(v === e, "display byte not found");
  endtask

  // Address command of a cell in the default four-row, twenty-column layout.
  function automatic logic [8:0] cell_addr(input int rw, input int cl);
    return 9'(int'(CMD_DDRAM) + (rw % 2) * 32'h40 + (rw / 2) * int'(COLS_DEF) + cl);
  endfunction

  task automatic spaces(input int k);
    for (int i = 0; i < k; i++) expect_b({1'b1, CH_SPACE});
  endtask

  initial begin
    void'($urandom(32'h084c));
    repeat (6) @(posedge clk_sys);
    check(lcd === '0 && piezo === 1'b0 && nv === '0, "outputs not idle in reset");
    #1 rst_b = 1'b1;
    expect_b({1'b0, CMD_WAKE1});
    expect_b({1'b0, CMD_WAKE2});
    expect_b({1'b0, CMD_FUNC});
    expect_b({1'b0, CMD_DISP | 8'h03});
    find({1'b1, 8'h34});
    for (int i = 0; i < s.len(); i++) expect_b({1'b1, s[i]});
    find({1'b0, CMD_CLEAR});
    c = 8'h40 + 8'($urandom_range(62));
    host.send(c);
    expect_b({1'b1, c});
    expect_b({1'b0, CMD_DDRAM | 8'h01});
    host.cmd("?y1?x10");
    host.send(c);
    find({1'b0, 8'hca});
    expect_b({1'b1, c});
    expect_b({1'b0, 8'hcb});
    host.cmd("??");
    expect_b({1'b1, CH_PREFIX});
    expect_b({1'b0, 8'hcc});
    host.cmd("?Q?a");
    expect_b({1'b0, CMD_DDRAM});
    host.cmd("?n?t?b?7?k?f?i?l?m?j?h");
    expect_b(cell_addr(1, 0));
    spaces(20);
    expect_b(cell_addr(1, 0));
    expect_b(cell_addr(1, 0));
    spaces(4);
    expect_b(cell_addr(1, 4));
    expect_b(cell_addr(1, 3));
    spaces(1);
    expect_b(cell_addr(1, 3));
    expect_b({1'b1, 8'h07});
    expect_b(cell_addr(1, 4));
    expect_b(cell_addr(0, 4));
    expect_b({1'b0, CMD_CLEAR});
    expect_b(cell_addr(0, 1));
    expect_b(cell_addr(0, 0));
    spaces(20);
    expect_b(cell_addr(0, 0));
    expect_b(cell_addr(0, 0));
    expect_b(cell_addr(1, 0));
    expect_b(cell_addr(0, 19));
    t0 = toggles;
    host.cmd("?g");
    repeat (200) @(posedge clk_sys);
    check(toggles - t0 == BEEP_T / HALF_T && piezo === 1'b0, "beep length wrong");
    host.cmd("?G216");
    repeat (300) @(posedge clk_sys);
    check(nv_seen.addr === NV_GEOM && nv_seen.data === 8'h10, "geometry store wrong");
    check(ovr_n == 0, "overrun while host paced");
    // Second power-up with the test input grounded; serial bytes must pile up unread.
    #1 rst_b = 1'b0;
    tm_b = 1'b0;
    repeat (2) @(posedge clk_sys);
    q.delete();
    check(lcd === '0 && piezo === 1'b0 && nv === '0, "outputs not idle in reset");
    #1 rst_b = 1'b1;
    repeat (65) host.send(c);
    repeat (4) @(posedge clk_sys);
    check(ovr_n == 1, "full buffer overrun not flagged once");
    find({1'b0, CMD_CLEAR});
    find({1'b0, CMD_CLEAR});
    expect_b({1'b1, TEST_LO});
    expect_b(cell_addr(0, 1));
    expect_b({1'b1, TEST_LO + 8'h1});
    end_sim();
  end
endmodule
